// ==== rtl/cap_ctrl_plane.sv ====
// Control and status plane of the crypto accelerator with Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
`include "cap_cfg.svh"
module cap_ctrl_plane
  import cap_pkg::*;
#(
  parameter int RST_CYCLES = `CAP_RST_CYCLES
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire cap_event_type evt_i,
  input wire logic key_dma_done_i,
  input wire logic [31:0] fifo_in_i,
  input wire logic fifo_in_full_i,
  input wire logic [31:0] fifo_out_i,
  input wire logic fifo_out_full_i,
  output logic [31:0] fifo_in_o,
  output logic [31:0] fifo_out_o,
  output cap_ctrl_type ctrl_o,
  output logic accel_rst_o,
  output logic irq_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] top_reg, top_next;
  logic [31:0] ciph_reg, ciph_next;
  logic [31:0] hash_reg, hash_next;
  logic [$clog2(RST_CYCLES+1)-1:0] rcnt_reg, rcnt_next;
  logic ack_reg;
  logic [31:0] rdat_reg;
  cap_ctrl_type ctrl_reg;
  logic [31:0] fin_reg, fout_reg;
  logic irq_reg, arst_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr = req & wb_we_i;
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire wr_top = wr & (wb_adr_i == `CAP_OFS_TOP);
  wire wr_ciph = wr & (wb_adr_i == `CAP_OFS_CIPHER);
  wire wr_hash = wr & (wb_adr_i == `CAP_OFS_HASH);
  wire busy = (rcnt_reg != '0);
  wire maa_done = ~evt_i.maa_busy; // [R05]

  //////////////////////////////////////////////////////////////////////////////
  // Done flags
  wire [3:0] flag_old = top_reg[`CAP_B_CPH:`CAP_B_DMA];
  wire [3:0] flag_wd = wb_dat_i[`CAP_B_CPH:`CAP_B_DMA];
  wire [3:0] flag_we = {4{wr_top}} & bmask[`CAP_B_CPH:`CAP_B_DMA];
  wire fmode = top_reg[`CAP_B_FMODE];
  wire dma_evt = evt_i.dma_done | (ciph_reg[`CAP_KEY_START] & key_dma_done_i); // [R08] [R20]
  wire gls_evt = evt_i.galois_fifo_full & evt_i.crc_or_ham_en; // [R07]
  wire [3:0] flag_set = {evt_i.cipher_done, evt_i.hash_done, gls_evt, dma_evt}; // [R06]
  // Software view of a write: free write or write-one-to-clear
  wire [3:0] flag_sw = fmode ? (flag_old & ~(flag_we & flag_wd)) // [R09]
                             : ((flag_old & ~flag_we) | (flag_we & flag_wd));
  wire [3:0] flag_new = flag_sw | flag_set; // set wins over clear
  wire sum_set = evt_i.cipher_done | evt_i.hash_done | gls_evt
                 | (top_reg[`CAP_B_DMAMSK] & dma_evt); // [R01] [R02]
  wire sum_clr = wr_top & bmask[`CAP_B_DONE] & (fmode ? wb_dat_i[`CAP_B_DONE] : ~wb_dat_i[`CAP_B_DONE]);
  wire sum_new = (top_reg[`CAP_B_DONE] & ~sum_clr) | sum_set;
  wire err_new = evt_i.bus_error | (top_reg[`CAP_B_ERR] & ~busy); // [R04]
  wire rst_req = wr_top & bmask[`CAP_B_RST] & wb_dat_i[`CAP_B_RST]; // [R15]

  always_comb begin
    top_next = (top_reg & ~(`CAP_TOP_WMASK & bmask & {32{wr_top}}))
             | (wb_dat_i & `CAP_TOP_WMASK & bmask & {32{wr_top}}); // [R23]
    top_next[`CAP_B_CPH:`CAP_B_DMA] = busy ? 4'h0 : flag_new; // [R16]
    top_next[`CAP_B_DONE] = busy ? 1'b0 : sum_new;
    top_next[`CAP_B_RDY] = ~(busy | rst_req); // [R03]
    top_next[`CAP_B_ERR] = err_new;
    top_next[`CAP_B_MAA] = 1'b0;
    top_next[`CAP_B_RST] = rst_req; // [R15]
    ciph_next = wr_ciph ? ((ciph_reg & ~bmask) | (wb_dat_i & bmask)) & `CAP_CIPH_WMASK : ciph_reg; // [R17] [R18]
    if (key_dma_done_i | busy) begin
      ciph_next[`CAP_KEY_START] = 1'b0; // [R20] [R16]
    end
    hash_next = wr_hash ? ((hash_reg & ~bmask) | (wb_dat_i & bmask)) & `CAP_HASH_WMASK : hash_reg; // [R22] [R21]
    if (key_dma_done_i | busy) begin
      hash_next[`CAP_XOR_START] = 1'b0;
    end
    if (busy) begin
      hash_next[`CAP_HASH_INIT] = 1'b0; // [R16]
    end
    rcnt_next = rst_req ? ($bits(rcnt_reg))'(RST_CYCLES) : (busy ? rcnt_reg - 1'b1 : rcnt_reg);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux and FIFO swap
  wire [31:0] top_view = {top_reg[31:29], maa_done, top_reg[27:0]}; // [R05]
  wire [31:0] rd_mux = (wb_adr_i == `CAP_OFS_TOP) ? top_view :
                       (wb_adr_i == `CAP_OFS_CIPHER) ? ciph_reg :
                       (wb_adr_i == `CAP_OFS_HASH) ? hash_reg : 32'h00000000; // [R23]
  function automatic logic [31:0] swap32(input logic [31:0] d);
    swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  wire [31:0] fin_mux = (top_reg[`CAP_B_BSI] & fifo_in_full_i) ? swap32(fifo_in_i) : fifo_in_i; // [R12]
  wire [31:0] fout_mux = (top_reg[`CAP_B_BSO] & fifo_out_full_i) ? swap32(fifo_out_i) : fifo_out_i; // [R12]

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      top_reg <= `CAP_TOP_RST;
      ciph_reg <= 32'h00000000;
      hash_reg <= 32'h00000000;
      rcnt_reg <= '0;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
      ctrl_reg <= '0;
      fin_reg <= 32'h00000000;
      fout_reg <= 32'h00000000;
      irq_reg <= 1'b0;
      arst_reg <= 1'b0;
    end else begin
      top_reg <= top_next;
      ciph_reg <= ciph_next;
      hash_reg <= hash_next;
      rcnt_reg <= rcnt_next;
      ack_reg <= req;
      rdat_reg <= rd_mux;
      fin_reg <= fin_mux;
      fout_reg <= fout_mux;
      irq_reg <= top_next[`CAP_B_INT] & (top_next[`CAP_B_DONE] | top_next[`CAP_B_ERR]); // [R14]
      arst_reg <= rst_req | (rcnt_next != '0);
      ctrl_reg.rd_src <= cap_rdsrc_type'(top_next[11:10]); // [R10]
      ctrl_reg.wr_src <= cap_wrsrc_type'(top_next[9:8]); // [R11]
      ctrl_reg.swap_in <= top_next[`CAP_B_BSI];
      ctrl_reg.swap_out <= top_next[`CAP_B_BSO];
      ctrl_reg.digest_src_out <= top_next[`CAP_B_SRC]; // [R13]
      ctrl_reg.cmode <= cap_cmode_type'(ciph_next[10:8]); // [R17]
      ctrl_reg.calg <= cap_calg_type'(ciph_next[6:4]); // [R18]
      ctrl_reg.key_src <= ciph_next[3:2]; // [R19]
      ctrl_reg.key_load <= ciph_next[`CAP_KEY_START];
      ctrl_reg.decrypt <= ciph_next[0];
      ctrl_reg.halg <= cap_halg_type'(hash_next[4:2]); // [R22]
      ctrl_reg.hash_last <= hash_next[5]; // [R21]
      ctrl_reg.hash_xor <= hash_next[`CAP_XOR_START];
      ctrl_reg.hash_init <= hash_next[`CAP_HASH_INIT];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign ctrl_o = ctrl_reg;
  assign fifo_in_o = fin_reg;
  assign fifo_out_o = fout_reg;
  assign accel_rst_o = arst_reg;
  assign irq_o = irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Ready returns one cycle after the reset counter has run out
  localparam int RDY_LAT = RST_CYCLES + 1;
  chk_sum_on_cipher: assert property (@(posedge mclk_i) disable iff (srst_i)
    evt_i.cipher_done && !busy |=> top_reg[`CAP_B_DONE]) else $error("summary flag missed cipher done"); // [R01]
  chk_dma_masked: assert property (@(posedge mclk_i) disable iff (srst_i)
    dma_evt && !top_reg[`CAP_B_DMAMSK] && !top_reg[`CAP_B_DONE] && !evt_i.cipher_done && !evt_i.hash_done
    && !gls_evt |=> !top_reg[`CAP_B_DONE]) else $error("masked DMA done set summary"); // [R02]
  chk_rdy_drop: assert property (@(posedge mclk_i) disable iff (srst_i)
    rst_req |=> !top_reg[`CAP_B_RDY] ##RDY_LAT top_reg[`CAP_B_RDY]) else $error("ready sequence wrong"); // [R03]
  chk_err_sticky: assert property (@(posedge mclk_i) disable iff (srst_i)
    top_reg[`CAP_B_ERR] && !busy |=> top_reg[`CAP_B_ERR]) else $error("bus error lost"); // [R04]
  chk_maa_inverse: assert property (@(posedge mclk_i) disable iff (srst_i) // [R05]
    req && !wb_we_i && (wb_adr_i == `CAP_OFS_TOP) |=> wb_dat_o[`CAP_B_MAA] == !$past(evt_i.maa_busy))
    else $error("MAA done not inverse of busy");
  chk_gls_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    gls_evt && !busy |=> top_reg[`CAP_B_GLS]) else $error("Galois done not set"); // [R07]
  chk_w1c_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    fmode && wr_top && !busy && top_reg[`CAP_B_CPH] && !wb_dat_i[`CAP_B_CPH] |=> top_reg[`CAP_B_CPH])
    else $error("write zero cleared flag in w1c mode"); // [R09]
  chk_rst_self: assert property (@(posedge mclk_i) disable iff (srst_i)
    top_reg[`CAP_B_RST] |=> !top_reg[`CAP_B_RST]) else $error("soft reset bit stuck"); // [R15]
  chk_irq_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    !top_reg[`CAP_B_INT] |-> !irq_o) else $error("interrupt while disabled"); // [R14]
  chk_key_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
    key_dma_done_i && ciph_reg[`CAP_KEY_START] && !busy |=> !ciph_reg[`CAP_KEY_START] && top_reg[`CAP_B_DMA])
    else $error("key load completion wrong"); // [R20]
  cov_soft_reset: cover property (@(posedge mclk_i) rst_req ##1 busy);
  cov_irq: cover property (@(posedge mclk_i) irq_o);
  cov_key_load: cover property (@(posedge mclk_i) ciph_reg[`CAP_KEY_START] ##[1:20] key_dma_done_i);
  chk_err_clear: assert property (@(posedge mclk_i) disable iff (srst_i) // [R04]
    busy && !evt_i.bus_error |=> !top_reg[`CAP_B_ERR]) else $error("bus error survived soft reset");
  chk_flags_reset: assert property (@(posedge mclk_i) disable iff (srst_i) // [R16]
    busy |=> top_reg[`CAP_B_CPH:`CAP_B_DMA] == 4'h0 && !top_reg[`CAP_B_DONE])
    else $error("done flags survived soft reset");
  chk_hash_done: assert property (@(posedge mclk_i) disable iff (srst_i) // [R06]
    evt_i.hash_done && !busy |=> top_reg[`CAP_B_HSH] && top_reg[`CAP_B_DONE]) else $error("hash done not set");
  chk_irq_on: assert property (@(posedge mclk_i) disable iff (srst_i) // [R14]
    top_reg[`CAP_B_INT] && (top_reg[`CAP_B_DONE] || top_reg[`CAP_B_ERR]) |-> irq_o)
    else $error("interrupt missing");
  chk_ack_pulse: assert property (@(posedge mclk_i) disable iff (srst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  cov_w1c: cover property (@(posedge mclk_i) fmode && wr_top);
  cov_dma_summary: cover property (@(posedge mclk_i) dma_evt && top_reg[`CAP_B_DMAMSK]);
endmodule
`default_nettype wire

// ==== rtl/cap_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the accelerator control plane
// Notes on behaviour
// R01 - Summary done flag sets when cipher, hash or Galois done sets; software clears it.
// R02 - DMA done also sets summary flag only when the DMA mask bit is one.
// R03 - Ready flag resets to one, drops during accelerator reset, returns when finished.
// R04 - Bus-error flag sets on failed DMA access; only accelerator reset clears it.
// R05 - Modular-arithmetic done reads as inverse of busy; not writable while busy.
// R06 - Cipher done sets on block completion; hash done sets on hash completion.
// R07 - Galois done sets when FIFO fills while CRC or Hamming is enabled.
// R08 - DMA done sets when an internal DMA read or write transfer finishes.
// R09 - Flag mode zero writes done flags freely; mode one is write-one-to-clear.
// R10 - Read FIFO source: 00 off, 01 DMA or bus, 10 random, 11 reserved.
// R11 - Write FIFO source: 00 none, 01 cipher output, 10 read FIFO, 11 reserved.
// R12 - Input and output byte-swap bits reverse bytes of full words only.
// R13 - Source bit routes hash and CRC input: 0 input FIFO, 1 output FIFO.
// R14 - With interrupt enable set, request raised while summary or error flag set.
// R15 - Writing one to soft-reset starts internal reset; bit self-clears next cycle.
// R16 - Soft reset clears internal state; control registers keep values except start bits.
// R17 - Cipher mode field: 000 ECB, 001 CBC, 010 CFB, 011 OFB, 100 CTR.
// R18 - Cipher algorithm field: disabled, AES-128/192/256, DES, TDEA; 110-111 reserved.
// R19 - Each key load moves 128 bits; two loads make a 256-bit key.
// R20 - Key-load bit starts DMA key fill; on finish bit clears, DMA done sets.
// R21 - Last-block bit with message size makes hash padding automatic.
// R22 - Hash select: disabled, SHA-1, SHA-224, SHA-256, SHA-384, SHA-512; 6-7 reserved.
// R23 - Reserved register bits read zero and ignore writes.
`ifndef CAP_CFG_SVH
`define CAP_CFG_SVH
`define CAP_OFS_TOP 8'h00
`define CAP_OFS_CIPHER 8'h04
`define CAP_OFS_HASH 8'h08
`define CAP_OFS_STATUS 8'h0C
`define CAP_B_DONE 31
`define CAP_B_RDY 30
`define CAP_B_ERR 29
`define CAP_B_MAA 28
`define CAP_B_CPH 27
`define CAP_B_HSH 26
`define CAP_B_GLS 25
`define CAP_B_DMA 24
`define CAP_B_DMAMSK 15
`define CAP_B_FMODE 14
`define CAP_B_BSI 5
`define CAP_B_BSO 4
`define CAP_B_SRC 2
`define CAP_B_INT 1
`define CAP_B_RST 0
`define CAP_TOP_WMASK 32'h0000CFF7
`define CAP_CIPH_WMASK 32'h0000077F
`define CAP_HASH_WMASK 32'h0000003F
`define CAP_KEY_START 1
`define CAP_XOR_START 1
`define CAP_HASH_INIT 0
`define CAP_TOP_RST 32'h40000000
`define CAP_RST_NS 100
`define CAP_CLK_NS 20
`define CAP_RST_CYCLES ((`CAP_RST_NS + `CAP_CLK_NS - 1) / `CAP_CLK_NS)
`endif

// ==== rtl/cap_pkg.sv ====
// Types of the accelerator control plane
package cap_pkg;
  typedef enum logic [1:0] {RDSRC_OFF, RDSRC_DMA, RDSRC_RNG, RDSRC_RSVD} cap_rdsrc_type;
  typedef enum logic [1:0] {WRSRC_NONE, WRSRC_CIPHER, WRSRC_RDFIFO, WRSRC_RSVD} cap_wrsrc_type;
  typedef enum logic [2:0] {CM_ECB, CM_CBC, CM_CFB, CM_OFB, CM_CTR, CM_R5, CM_R6, CM_R7} cap_cmode_type;
  typedef enum logic [2:0] {CA_OFF, CA_AES128, CA_AES192, CA_AES256, CA_DES, CA_TDEA, CA_R6, CA_R7}
    cap_calg_type;
  typedef enum logic [2:0] {HA_OFF, HA_SHA1, HA_SHA224, HA_SHA256, HA_SHA384, HA_SHA512, HA_R6, HA_R7}
    cap_halg_type;
  typedef struct packed {
    logic cipher_done;
    logic hash_done;
    logic galois_fifo_full;
    logic crc_or_ham_en;
    logic dma_done;
    logic bus_error;
    logic maa_busy;
  } cap_event_type;
  typedef struct packed {
    cap_rdsrc_type rd_src;
    cap_wrsrc_type wr_src;
    logic swap_in;
    logic swap_out;
    logic digest_src_out;
    cap_cmode_type cmode;
    cap_calg_type calg;
    logic [1:0] key_src;
    logic key_load;
    logic decrypt;
    cap_halg_type halg;
    logic hash_last;
    logic hash_xor;
    logic hash_init;
  } cap_ctrl_type;
endpackage

// ==== verif/crypto_accel_control_plane_tb_top.sv ====
// Self-checking testbench of the accelerator control plane
`timescale 1ns/10ps
`default_nettype none
module crypto_accel_control_plane_tb_top import cap_pkg::*; ;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, kdone = 1'b0, finf = 1'b0, foutf = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, fin = 32'h11223344, fout = 32'hA1B2C3D4;
  logic [31:0] wb_dat_o, fifo_in_o, fifo_out_o, q;
  logic wb_ack_o, accel_rst_o, irq_o, rst_seen;
  cap_event_type ev = '0;
  cap_ctrl_type ctrl_o;
  int n_fail = 0;
  int checks_done = 0;
  cap_ctrl_plane #(.RST_CYCLES(1)) u_cap_ctrl_plane (.mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .evt_i(ev), .key_dma_done_i(kdone), .fifo_in_i(fin), .fifo_in_full_i(finf),
    .fifo_out_i(fout), .fifo_out_full_i(foutf), .fifo_in_o(fifo_in_o), .fifo_out_o(fifo_out_o),
    .ctrl_o(ctrl_o), .accel_rst_o(accel_rst_o), .irq_o(irq_o));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Classic Wishbone cycle: hold until ack is sampled high, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rst_seen = accel_rst_o;
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge mclk_i);
    ev <= cap_event_type'(e);
    @(posedge mclk_i);
    ev <= '0;
    repeat (2) @(posedge mclk_i);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'h00, 32'h50000000);
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h0);
    ev <= cap_event_type'(7'h01);
    wr(8'h00, 32'h10000000);
    rd(8'h00, 32'h40000000);
    ev <= '0;
    $display("reset test done");
  endtask
  task automatic t_flags();
    pulse(7'h40);
    rd(8'h00, 32'hD8000000);
    wr(8'h00, 32'h0);
    pulse(7'h04);
    rd(8'h00, 32'h51000000);
    wr(8'h00, 32'h00008000);
    pulse(7'h04);
    rd(8'h00, 32'hD1008000);
    wr(8'h00, 32'h00004000);
    pulse(7'h20);
    wr(8'h00, 32'h00004000);
    rd(8'h00, 32'hD4004000);
    wr(8'h00, 32'h84004000);
    rd(8'h00, 32'h50004000);
    wr(8'h00, 32'h0);
    $display("flag test done");
  endtask
  task automatic t_irq();
    pulse(7'h10);
    rd(8'h00, 32'h50000000);
    pulse(7'h18);
    @(negedge mclk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h00, 32'h02000002);
    @(negedge mclk_i);
    chk({31'h0, irq_o}, 32'h0);
    pulse(7'h18);
    rd(8'h00, 32'hD2000002);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h00, 32'h0);
    $display("irq test done");
  endtask
  task automatic t_route();
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {20'h0, i[1:0], 2'(3 - i), 5'h0, i[0], 2'h0});
      chk({30'h0, ctrl_o.rd_src}, {30'h0, i[1:0]});
      chk({30'h0, ctrl_o.wr_src}, {30'h0, 2'(3 - i)});
      chk({31'h0, ctrl_o.digest_src_out}, {31'h0, i[0]});
    end
    wr(8'h00, 32'h00000030);
    finf <= 1'b1;
    foutf <= 1'b1;
    repeat (2) @(negedge mclk_i);
    chk(fifo_in_o, 32'h44332211);
    chk(fifo_out_o, 32'hD4C3B2A1);
    finf <= 1'b0;
    foutf <= 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(fifo_in_o, 32'h11223344);
    chk(fifo_out_o, 32'hA1B2C3D4);
    $display("route test done");
  endtask
  task automatic t_cipher();
    wr(8'h04, 32'hFFFFFC5E);
    rd(8'h04, 32'h0000045E);
    chk({29'h0, ctrl_o.cmode}, {29'h0, CM_CTR});
    chk({29'h0, ctrl_o.calg}, {29'h0, CA_TDEA});
    chk({29'h0, ctrl_o.key_src, ctrl_o.key_load}, 32'h7);
    @(posedge mclk_i);
    kdone <= 1'b1;
    @(posedge mclk_i);
    kdone <= 1'b0;
    rd(8'h04, 32'h0000045C);
    chk({31'h0, ctrl_o.key_load}, 32'h0);
    rd(8'h00, 32'h51000030);
    wr(8'h08, 32'hFFFFFFF4);
    rd(8'h08, 32'h00000034);
    chk({29'h0, ctrl_o.halg}, {29'h0, HA_SHA512});
    chk({31'h0, ctrl_o.hash_last}, 32'h1);
    $display("cipher test done");
  endtask
  task automatic t_srst();
    int n;
    pulse(7'h02);
    wr(8'h00, 32'h00000002);
    rd(8'h00, 32'h70000002);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h00, 32'h00000433);
    chk({31'h0, rst_seen}, 32'h1);
    n = 0;
    do begin
      wb(1'b0, 8'h00, 32'h0, q);
      n++;
    end while (q[30] !== 1'b1 && n < 10);
    if (q[30] !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    rd(8'h00, 32'h50000432);
    rd(8'h04, 32'h0000045C);
    chk({31'h0, irq_o}, 32'h0);
    $display("soft reset test done");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_reset();
    t_flags();
    t_irq();
    t_route();
    t_cipher();
    t_srst();
    wrap_up();
  end
endmodule
`default_nettype wire
